/* File: core/mmuac_pkg.sv */
// Constants, types and decode helpers for the MMU attribute access control
package mmuac_pkg;

	// Bus widths
	localparam int SFR_AW = 8;
	localparam int SFR_DW = 8;
	localparam int MEM_AW = 16;

	// CPU modes, gray-adjacent along boot, test, system, user
	typedef enum logic [2:0] {
		MD_BOOT = 3'h0,
		MD_TEST = 3'h1,
		MD_SYS = 3'h3,
		MD_USER = 3'h2,
		MD_CLESS = 3'h6
	} mmuac_mode_t;

	// Register addresses in the special function register space
	localparam logic [SFR_AW-1:0] SFR_STB_LO = 8'h10;
	localparam logic [SFR_AW-1:0] SFR_STB_HI = 8'h11;
	localparam logic [SFR_AW-1:0] SFR_XBASE = 8'h12;
	localparam logic [SFR_AW-1:0] SFR_XSIZE = 8'h13;
	localparam logic [SFR_AW-1:0] SFR_STATUS = 8'h14;
	localparam logic [SFR_AW-1:0] SFR_KEY_A = 8'h20;

	// Reset values
	localparam logic [SFR_DW-1:0] STB_RST = 8'h00;
	localparam logic [SFR_DW-1:0] XBASE_RST = 8'h00;
	localparam logic [SFR_DW-1:0] XSIZE_RST = 8'h00;
	localparam logic [SFR_DW-1:0] KEY_RST = 8'h00;
	localparam logic [SFR_DW-1:0] RD_ZERO = 8'h00;

	// Fixed memory partition
	localparam logic [MEM_AW-1:0] ROM_LO = 16'h0000;
	localparam logic [MEM_AW-1:0] ROM_HI = 16'h7fff;
	localparam logic [MEM_AW-1:0] AEEP_LO = 16'h8000;
	localparam logic [MEM_AW-1:0] AEEP_HI = 16'hbfff;
	localparam logic [MEM_AW-1:0] CEEP_LO = 16'hc000;
	localparam logic [MEM_AW-1:0] CEEP_HI = 16'hdfff;
	localparam logic [MEM_AW-1:0] ARAM_LO = 16'he000;
	localparam logic [MEM_AW-1:0] ARAM_HI = 16'hefff;
	localparam logic [MEM_AW-1:0] CRAM_LO = 16'hf000;
	localparam logic [MEM_AW-1:0] CRAM_HI = 16'hffff;

	// Exchange window granule: base and size count 16-byte blocks
	localparam int XGRAN_SH = 4;

	// Status register bit positions
	localparam int ST_SEGEN = 0;
	localparam int ST_MODE_LSB = 1;

	function automatic logic in_rng(input logic [MEM_AW-1:0] a,
		input logic [MEM_AW-1:0] lo, input logic [MEM_AW-1:0] hi);
		in_rng = (a >= lo) && (a <= hi);
	endfunction

endpackage

/* File: core/mmuac_sfr_perm.sv */
// Per-register read and write permission for special function registers
`timescale 1ns/1ps
module mmuac_sfr_perm import mmuac_pkg::*; #(
	parameter bit REDUCED_CFG = 1'b0
) (
	// Access
	input wire mmuac_mode_t mode,
	input wire logic [SFR_AW-1:0] addr,
	// User-mode rights from the executing segment
	input wire logic seg_sfr_rd,
	input wire logic seg_sfr_wr,
	// Verdict
	output logic rd_ok,
	output logic wr_ok
);
	wire is_seg = (addr == SFR_STB_LO) || (addr == SFR_STB_HI);
	wire is_xwin = (addr == SFR_XBASE) || (addr == SFR_XSIZE);
	wire is_stat = (addr == SFR_STATUS);
	wire is_key = (addr == SFR_KEY_A);
	wire is_sys = (mode == MD_SYS);
	wire is_priv = (mode == MD_BOOT) || (mode == MD_TEST) || is_sys;
	wire user_hw_wr = (mode == MD_USER) && seg_sfr_wr;
	wire user_hw_rd = (mode == MD_USER) && seg_sfr_rd;
	// Key is never readable; reduced builds lock it out entirely
	wire key_wr = !REDUCED_CFG && (is_priv || user_hw_wr);

	always_comb begin
		rd_ok = 1'b0;
		wr_ok = 1'b0;
		if (is_seg) begin
			rd_ok = is_sys;
			wr_ok = is_sys;
		end else if (is_xwin) begin
			rd_ok = is_sys || (mode == MD_CLESS);
			wr_ok = is_sys;
		end else if (is_stat) begin
			rd_ok = is_priv || user_hw_rd || (mode == MD_CLESS);
		end else if (is_key) begin
			wr_ok = key_wr;
		end
	end
endmodule

/* File: core/mmuac_mem_check.sv */
// Memory access check against the fixed partition and segment rights
`timescale 1ns/1ps
module mmuac_mem_check import mmuac_pkg::*; (
	// Access
	input wire mmuac_mode_t mode,
	input wire logic [MEM_AW-1:0] addr,
	input wire logic we,
	input wire logic ex,
	// Segment state
	input wire logic segs_en,
	input wire logic seg_rd,
	input wire logic seg_wr,
	input wire logic seg_ex,
	// Exchange window in blocks
	input wire logic [SFR_DW-1:0] xbase,
	input wire logic [SFR_DW-1:0] xsize,
	// Verdict
	output logic ok
);
	wire r_rom = in_rng(addr, ROM_LO, ROM_HI);
	wire r_aeep = in_rng(addr, AEEP_LO, AEEP_HI);
	wire r_ceep = in_rng(addr, CEEP_LO, CEEP_HI);
	wire r_aram = in_rng(addr, ARAM_LO, ARAM_HI);
	wire r_cram = in_rng(addr, CRAM_LO, CRAM_HI);
	wire [MEM_AW-1:0] x_lo = ARAM_LO + MEM_AW'({xbase, XGRAN_SH'(0)});
	wire [MEM_AW-1:0] x_end = x_lo + MEM_AW'({xsize, XGRAN_SH'(0)});
	wire in_x = r_aram && (addr >= x_lo) && (addr < x_end);
	wire rd_only = !we;
	wire no_ex = !ex;
	// Table entries get ordinary rights only, no special region
	wire usr_ok = segs_en && (r_rom || r_aeep || r_aram) &&
		(!we || seg_wr) && (!ex || seg_ex) && (we || ex || seg_rd) &&
		!(r_rom && we) && !(r_aram && ex);

	always_comb begin
		ok = 1'b0;
		case (mode)
		MD_TEST: begin
			ok = !(r_rom && we) && !((r_aram || r_cram) && ex);
		end
		MD_BOOT: begin
			ok = (r_rom && !we) || r_ceep || (r_cram && no_ex);
		end
		MD_CLESS: begin
			ok = (r_rom && rd_only && no_ex) || r_ceep ||
				((r_cram || in_x) && no_ex);
		end
		MD_SYS: begin
			ok = (r_rom && !we) || r_aeep || (r_aram && no_ex);
		end
		MD_USER: begin
			ok = usr_ok;
		end
		default: begin
			ok = 1'b0;
		end
		endcase
	end
endmodule

/* File: core/mmuac_top.sv */
// MMU security attribute registers, reset defaults and access gating
//
// Behaviour
// - Reset clears segment table base to zero
// - Zero base disables user segment memory rights, not segment register rights
// - No way to override reset defaults
// - System mode writes segmentation registers
// - User mode blocked from segmentation registers
// - Table contents use normal memory rights
// - No extra protection on table entries
// - Attribute changes need register write permission
// - Memory partition is hard-wired
// - Attribute register set is fixed
// - Contactless mode isolated, small exchange window
// - Exchange window controlled by system mode
// - Reduced builds: key register fully inaccessible
// - Refused read gives zero, write dropped
`timescale 1ns/1ps
module mmuac_top import mmuac_pkg::*; #(
	parameter bit REDUCED_CFG = 1'b0
) (
	// Clock, reset, enable
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// CPU mode of the current instruction
	input wire mmuac_mode_t cpu_mode,
	// Special function register access
	input wire logic sfr_req,
	input wire logic sfr_we,
	input wire logic [SFR_AW-1:0] sfr_addr,
	input wire logic [SFR_DW-1:0] sfr_wdata,
	output logic sfr_ack_ff,
	output logic sfr_deny_ff,
	output logic [SFR_DW-1:0] sfr_rdata_ff,
	// Memory access
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic mem_ex,
	input wire logic [MEM_AW-1:0] mem_addr,
	output logic mem_ack_ff,
	output logic mem_grant_ff,
	// Rights of the executing segment, from the table walker
	input wire logic seg_rd,
	input wire logic seg_wr,
	input wire logic seg_ex,
	input wire logic seg_sfr_rd,
	input wire logic seg_sfr_wr,
	// Attribute state towards the MMU and crypto unit
	output logic [SFR_DW-1:0] stb_lo_ff,
	output logic [SFR_DW-1:0] stb_hi_ff,
	output logic segs_en_ff,
	output logic [SFR_DW-1:0] cipher_key_a_register_ff
);
	logic [SFR_DW-1:0] xbase_ff;
	logic [SFR_DW-1:0] xsize_ff;
	logic rd_ok;
	logic wr_ok;
	logic mem_ok;

	// Permission is combinational on the mode presented with the access
	mmuac_sfr_perm #(
		.REDUCED_CFG(REDUCED_CFG)
	) u_perm (
		.mode(cpu_mode),
		.addr(sfr_addr),
		.seg_sfr_rd(seg_sfr_rd),
		.seg_sfr_wr(seg_sfr_wr),
		.rd_ok(rd_ok),
		.wr_ok(wr_ok)
	);

	// Segments count as enabled only once a base has been programmed
	wire segs_en = (stb_lo_ff != STB_RST) || (stb_hi_ff != STB_RST);

	mmuac_mem_check u_mem (
		.mode(cpu_mode),
		.addr(mem_addr),
		.we(mem_we),
		.ex(mem_ex),
		.segs_en(segs_en_ff),
		.seg_rd(seg_rd),
		.seg_wr(seg_wr),
		.seg_ex(seg_ex),
		.xbase(xbase_ff),
		.xsize(xsize_ff),
		.ok(mem_ok)
	);

	// Write strobes per register; no other write path exists
	wire wr_go = ce && sfr_req && sfr_we && wr_ok;
	wire wr_stb_lo = wr_go && (sfr_addr == SFR_STB_LO);
	wire wr_stb_hi = wr_go && (sfr_addr == SFR_STB_HI);
	wire wr_xbase = wr_go && (sfr_addr == SFR_XBASE);
	wire wr_xsize = wr_go && (sfr_addr == SFR_XSIZE);
	wire wr_key = wr_go && (sfr_addr == SFR_KEY_A);

	// Read selection; a refused or unmapped read yields zero
	wire [SFR_DW-1:0] stat_val = SFR_DW'({cpu_mode, segs_en_ff});
	wire [SFR_DW-1:0] rd_sel =
		!rd_ok ? RD_ZERO :
		(sfr_addr == SFR_STB_LO) ? stb_lo_ff :
		(sfr_addr == SFR_STB_HI) ? stb_hi_ff :
		(sfr_addr == SFR_XBASE) ? xbase_ff :
		(sfr_addr == SFR_XSIZE) ? xsize_ff :
		(sfr_addr == SFR_STATUS) ? stat_val : RD_ZERO;
	wire refused = sfr_we ? !wr_ok : !rd_ok;

	// Reset values are constants; nothing loads alternative defaults
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			stb_lo_ff <= STB_RST;
			stb_hi_ff <= STB_RST;
		end else begin
			if (wr_stb_lo) begin
				stb_lo_ff <= sfr_wdata;
			end
			if (wr_stb_hi) begin
				stb_hi_ff <= sfr_wdata;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			xbase_ff <= XBASE_RST;
			xsize_ff <= XSIZE_RST;
		end else begin
			if (wr_xbase) begin
				xbase_ff <= sfr_wdata;
			end
			if (wr_xsize) begin
				xsize_ff <= sfr_wdata;
			end
		end
	end

	// Key is write-only; its value never reaches the read path
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cipher_key_a_register_ff <= KEY_RST;
		end else if (wr_key) begin
			cipher_key_a_register_ff <= sfr_wdata;
		end
	end

	// Segment enable follows the base one cycle after a write
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			segs_en_ff <= 1'b0;
		end else if (ce) begin
			segs_en_ff <= segs_en;
		end
	end

	// Register answer, one cycle after the request
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sfr_ack_ff <= 1'b0;
			sfr_deny_ff <= 1'b0;
			sfr_rdata_ff <= RD_ZERO;
		end else if (ce) begin
			sfr_ack_ff <= sfr_req;
			sfr_deny_ff <= sfr_req && refused;
			sfr_rdata_ff <= (sfr_req && !sfr_we) ? rd_sel : RD_ZERO;
		end
	end

	// Memory answer, one cycle after the request
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mem_ack_ff <= 1'b0;
			mem_grant_ff <= 1'b0;
		end else if (ce) begin
			mem_ack_ff <= mem_req;
			mem_grant_ff <= mem_req && mem_ok;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	property p_rst_base;
		@(posedge clk) disable iff (1'b0)
		!rst_n |=> (stb_lo_ff == STB_RST) && (stb_hi_ff == STB_RST)
			&& !segs_en_ff;
	endproperty
	a_rst_base: assert property (p_rst_base)
		else $error("base not cleared by reset");

	property p_no_user_seg;
		ce && mem_req && (cpu_mode == MD_USER) && !segs_en_ff
			|=> !mem_grant_ff;
	endproperty
	a_no_user_seg: assert property (p_no_user_seg)
		else $error("user access granted with zero base");

	property p_user_base_locked;
		ce && sfr_req && sfr_we && (cpu_mode != MD_SYS) &&
			(sfr_addr == SFR_STB_LO || sfr_addr == SFR_STB_HI)
			|=> $stable(stb_lo_ff) && $stable(stb_hi_ff) && sfr_deny_ff;
	endproperty
	a_user_base_locked: assert property (p_user_base_locked)
		else $error("non-system mode changed table base");

	property p_sys_base_wr;
		ce && sfr_req && sfr_we && (cpu_mode == MD_SYS) &&
			(sfr_addr == SFR_STB_LO)
			|=> (stb_lo_ff == $past(sfr_wdata)) and
			(ce && (stb_lo_ff != STB_RST) |=> segs_en_ff);
	endproperty
	a_sys_base_wr: assert property (p_sys_base_wr)
		else $error("system write to table base lost");

	property p_deny_zero;
		ce && sfr_req && !sfr_we && !rd_ok
			|=> sfr_ack_ff && sfr_deny_ff && (sfr_rdata_ff == RD_ZERO);
	endproperty
	a_deny_zero: assert property (p_deny_zero)
		else $error("refused read returned data");

	property p_key_hidden;
		ce && sfr_req && !sfr_we && (sfr_addr == SFR_KEY_A)
			|=> sfr_ack_ff && (sfr_rdata_ff == RD_ZERO) && sfr_deny_ff;
	endproperty
	a_key_hidden: assert property (p_key_hidden)
		else $error("key register readable");

	property p_key_reduced;
		REDUCED_CFG && sfr_req && sfr_we && (sfr_addr == SFR_KEY_A)
			|=> $stable(cipher_key_a_register_ff);
	endproperty
	a_key_reduced: assert property (p_key_reduced)
		else $error("key written in reduced build");

	property p_xwin_sys;
		sfr_req && sfr_we && (cpu_mode != MD_SYS) &&
			(sfr_addr == SFR_XBASE || sfr_addr == SFR_XSIZE)
			|=> $stable(xbase_ff) && $stable(xsize_ff);
	endproperty
	a_xwin_sys: assert property (p_xwin_sys)
		else $error("exchange window changed outside system mode");

	property p_partition;
		ce && mem_req && (cpu_mode == MD_SYS) &&
			in_rng(mem_addr, CEEP_LO, CRAM_HI) &&
			!in_rng(mem_addr, ARAM_LO, ARAM_HI)
			|=> mem_ack_ff && !mem_grant_ff;
	endproperty
	a_partition: assert property (p_partition)
		else $error("system mode reached contactless memory");

	property p_ack_next;
		ce && sfr_req |=> sfr_ack_ff ##1 (ce && !sfr_req) |=> !sfr_ack_ff;
	endproperty
	a_ack_next: assert property (p_ack_next)
		else $error("register answer not one cycle after request");

	c_sys_base: cover property (ce && wr_stb_hi ##1 segs_en);
	c_user_grant: cover property (ce && mem_req &&
		(cpu_mode == MD_USER) ##1 mem_grant_ff);
	c_cless_xwin: cover property (ce && mem_req &&
		(cpu_mode == MD_CLESS) && mem_addr[MEM_AW-1 -: 4] == 4'he
		##1 mem_grant_ff);
	c_deny: cover property (ce && sfr_req ##1 sfr_deny_ff);
endmodule

/* File: verif/mmuac_cpu_model.sv */
// CPU core model issuing mode-tagged register and memory accesses
`timescale 1ns/1ps
module mmuac_cpu_model import mmuac_pkg::*; (
	// Clock
	input wire logic clk,
	// Requests
	output mmuac_mode_t cpu_mode,
	output logic sfr_req,
	output logic sfr_we,
	output logic [SFR_AW-1:0] sfr_addr,
	output logic [SFR_DW-1:0] sfr_wdata,
	output logic mem_req,
	output logic mem_we,
	output logic mem_ex,
	output logic [MEM_AW-1:0] mem_addr,
	// Segment rights: rd, wr, ex, register rd, register wr
	output logic [4:0] seg,
	// Answers
	input wire logic sfr_ack_ff,
	input wire logic sfr_deny_ff,
	input wire logic [SFR_DW-1:0] sfr_rdata_ff,
	input wire logic mem_ack_ff,
	input wire logic mem_grant_ff
);
	initial begin
		cpu_mode = MD_SYS;
		{sfr_req, sfr_we, sfr_addr, sfr_wdata} = '0;
		{mem_req, mem_we, mem_ex, mem_addr, seg} = '0;
	end

	task automatic set_seg(input logic [4:0] v);
		@(posedge clk);
		#1;
		seg = v;
	endtask

	task automatic sfr(input mmuac_mode_t m, input logic we,
		input logic [SFR_AW-1:0] a, input logic [SFR_DW-1:0] d,
		output logic [SFR_DW-1:0] rd, output logic dn, output logic ak);
		@(posedge clk);
		#1;
		cpu_mode = m;
		{sfr_req, sfr_we, sfr_addr, sfr_wdata} = {1'b1, we, a, d};
		@(posedge clk);
		#1;
		// Released lines flip so stale values are never trusted
		{sfr_req, sfr_addr, sfr_wdata} = {1'b0, ~a, ~d};
		{rd, dn, ak} = {sfr_rdata_ff, sfr_deny_ff, sfr_ack_ff};
	endtask

	task automatic mem(input mmuac_mode_t m, input logic we, input logic ex,
		input logic [MEM_AW-1:0] a, output logic gr, output logic ak);
		@(posedge clk);
		#1;
		cpu_mode = m;
		{mem_req, mem_we, mem_ex, mem_addr} = {1'b1, we, ex, a};
		@(posedge clk);
		#1;
		{mem_req, mem_addr} = {1'b0, ~a};
		{gr, ak} = {mem_grant_ff, mem_ack_ff};
	endtask
endmodule

/* File: verif/tb_mmuac_top.sv */
// Self-checking bench for the MMU attribute access control
`timescale 1ns/1ps
module tb_mmuac_top;
	import mmuac_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	mmuac_mode_t cpu_mode;
	logic sfr_req, sfr_we, mem_req, mem_we, mem_ex, segs_en_ff;
	logic sfr_ack_ff, sfr_deny_ff, mem_ack_ff, mem_grant_ff;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata_ff, stb_lo_ff, stb_hi_ff;
	logic [7:0] key_ff, key_red;
	logic ce = 1'b1;
	logic r_ack, r_deny, r_mack, r_grant, r_segs;
	logic [7:0] r_rdata, r_stb_lo, r_stb_hi;
	logic [15:0] mem_addr;
	logic [4:0] seg;
	int miscompares = 0;
	int tests_run = 0;
	int cycles = 0;

	always #20 clk = ~clk;

	mmuac_cpu_model mmuac_cpu_model_inst (.clk(clk), .cpu_mode(cpu_mode),
		.sfr_req(sfr_req), .sfr_we(sfr_we), .sfr_addr(sfr_addr),
		.sfr_wdata(sfr_wdata), .mem_req(mem_req), .mem_we(mem_we),
		.mem_ex(mem_ex), .mem_addr(mem_addr), .seg(seg),
		.sfr_ack_ff(sfr_ack_ff), .sfr_deny_ff(sfr_deny_ff),
		.sfr_rdata_ff(sfr_rdata_ff), .mem_ack_ff(mem_ack_ff),
		.mem_grant_ff(mem_grant_ff));

	mmuac_top #(.REDUCED_CFG(1'b0)) mmuac_top_inst (.clk(clk),
		.rst_n(rst_n), .ce(ce), .cpu_mode(cpu_mode), .sfr_req(sfr_req),
		.sfr_we(sfr_we), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
		.sfr_ack_ff(sfr_ack_ff), .sfr_deny_ff(sfr_deny_ff),
		.sfr_rdata_ff(sfr_rdata_ff), .mem_req(mem_req), .mem_we(mem_we),
		.mem_ex(mem_ex), .mem_addr(mem_addr), .mem_ack_ff(mem_ack_ff),
		.mem_grant_ff(mem_grant_ff), .seg_rd(seg[4]), .seg_wr(seg[3]),
		.seg_ex(seg[2]), .seg_sfr_rd(seg[1]), .seg_sfr_wr(seg[0]),
		.stb_lo_ff(stb_lo_ff), .stb_hi_ff(stb_hi_ff),
		.segs_en_ff(segs_en_ff), .cipher_key_a_register_ff(key_ff));

	// Reduced build shares the stimulus; its answers are checked too
	mmuac_top #(.REDUCED_CFG(1'b1)) mmuac_top_inst_red (.clk(clk),
		.rst_n(rst_n), .ce(ce), .cpu_mode(cpu_mode), .sfr_req(sfr_req),
		.sfr_we(sfr_we), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
		.sfr_ack_ff(r_ack), .sfr_deny_ff(r_deny),
		.sfr_rdata_ff(r_rdata), .mem_req(mem_req),
		.mem_we(mem_we), .mem_ex(mem_ex), .mem_addr(mem_addr),
		.mem_ack_ff(r_mack), .mem_grant_ff(r_grant),
		.seg_rd(seg[4]), .seg_wr(seg[3]),
		.seg_ex(seg[2]), .seg_sfr_rd(seg[1]), .seg_sfr_wr(seg[0]),
		.stb_lo_ff(r_stb_lo), .stb_hi_ff(r_stb_hi), .segs_en_ff(r_segs),
		.cipher_key_a_register_ff(key_red));

	task automatic print_verdict();
		$display("Counts: %0d compared, %0d mismatched", tests_run,
			miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			miscompares++;
			print_verdict();
		end
	end

	task automatic chk(input logic [7:0] s, input logic [7:0] e,
		input string msg);
		tests_run++;
		if (s !== e) begin
			miscompares++;
			$display("BAD at %0t: %s seen %h expected %h", $time, msg, s, e);
		end
	endtask

	task automatic sw(input mmuac_mode_t m, input logic [7:0] a,
		input logic [7:0] d, input logic dn);
		logic [7:0] rd;
		logic de, ak;
		mmuac_cpu_model_inst.sfr(m, 1'b1, a, d, rd, de, ak);
		chk({7'h0, ak}, 8'h01, "write ack");
		chk({7'h0, de}, {7'h0, dn}, "write deny");
	endtask

	task automatic sr(input mmuac_mode_t m, input logic [7:0] a,
		input logic [7:0] e, input logic dn);
		logic [7:0] rd;
		logic de, ak;
		mmuac_cpu_model_inst.sfr(m, 1'b0, a, 8'h00, rd, de, ak);
		chk({7'h0, ak}, 8'h01, "read ack");
		chk({7'h0, de}, {7'h0, dn}, "read deny");
		chk(rd, e, "read data");
	endtask

	task automatic mc(input mmuac_mode_t m, input logic we, input logic ex,
		input logic [15:0] a, input logic g);
		logic gr, ak;
		mmuac_cpu_model_inst.mem(m, we, ex, a, gr, ak);
		chk({7'h0, ak}, 8'h01, "memory ack");
		chk({7'h0, gr}, {7'h0, g}, "memory grant");
	endtask

	task automatic t_reset();
		mmuac_cpu_model_inst.set_seg(5'h1f);
		chk(stb_lo_ff, STB_RST, "base low");
		chk(stb_hi_ff, STB_RST, "base high");
		chk({7'h0, segs_en_ff}, 8'h00, "segments on");
		mc(MD_USER, 1'b0, 1'b1, AEEP_LO, 1'b0);
		mc(MD_USER, 1'b1, 1'b0, ARAM_LO, 1'b0);
		$display("Test reset defaults done");
	endtask

	task automatic t_seg_cfg();
		sw(MD_SYS, SFR_STB_LO, 8'h55, 1'b0);
		sw(MD_SYS, SFR_STB_HI, 8'ha0, 1'b0);
		chk(stb_lo_ff, 8'h55, "base low");
		chk(stb_hi_ff, 8'ha0, "base high");
		sr(MD_SYS, SFR_STB_LO, 8'h55, 1'b0);
		chk(r_rdata, 8'h55, "reduced base read");
		sr(MD_SYS, SFR_STATUS, 8'h07, 1'b0);
		mc(MD_USER, 1'b0, 1'b1, AEEP_LO, 1'b1);
		chk({6'h0, r_mack, r_grant}, 8'h03, "reduced grant");
		chk({7'h0, r_segs}, 8'h01, "reduced segments");
		sw(MD_USER, SFR_STB_LO, 8'haa, 1'b1);
		sw(MD_BOOT, SFR_STB_HI, 8'h11, 1'b1);
		sw(MD_CLESS, SFR_STB_HI, 8'h22, 1'b1);
		sr(MD_USER, SFR_STB_HI, 8'h00, 1'b1);
		chk(stb_lo_ff, 8'h55, "base low kept");
		chk(stb_hi_ff, 8'ha0, "base high kept");
		chk(r_stb_lo, 8'h55, "reduced base low");
		chk(r_stb_hi, 8'ha0, "reduced base high");
		sr(MD_USER, SFR_STATUS, 8'h05, 1'b0);
		$display("Test segmentation registers done");
	endtask

	task automatic t_table();
		mc(MD_USER, 1'b1, 1'b0, 16'he020, 1'b1);
		mmuac_cpu_model_inst.set_seg(5'h17);
		mc(MD_USER, 1'b1, 1'b0, 16'he020, 1'b0);
		mc(MD_USER, 1'b0, 1'b0, 16'he020, 1'b1);
		mc(MD_SYS, 1'b1, 1'b0, 16'he020, 1'b1);
		mmuac_cpu_model_inst.set_seg(5'h1f);
		$display("Test table in memory done");
	endtask

	task automatic t_partition();
		mc(MD_SYS, 1'b1, 1'b0, ROM_LO, 1'b0);
		mc(MD_SYS, 1'b0, 1'b0, CEEP_LO, 1'b0);
		mc(MD_SYS, 1'b0, 1'b0, CRAM_LO, 1'b0);
		mc(MD_SYS, 1'b0, 1'b1, ARAM_LO, 1'b0);
		mc(MD_USER, 1'b0, 1'b0, CRAM_HI, 1'b0);
		mc(MD_CLESS, 1'b0, 1'b0, AEEP_LO, 1'b0);
		mc(MD_CLESS, 1'b1, 1'b0, CRAM_LO, 1'b1);
		mc(MD_CLESS, 1'b0, 1'b1, CEEP_HI, 1'b1);
		mc(MD_BOOT, 1'b1, 1'b0, AEEP_HI, 1'b0);
		$display("Test fixed partition done");
	endtask

	task automatic t_xwin();
		mc(MD_CLESS, 1'b1, 1'b0, ARAM_LO, 1'b0);
		sw(MD_CLESS, SFR_XSIZE, 8'h01, 1'b1);
		sw(MD_SYS, SFR_XBASE, 8'h02, 1'b0);
		sw(MD_SYS, SFR_XSIZE, 8'h01, 1'b0);
		sr(MD_CLESS, SFR_XBASE, 8'h02, 1'b0);
		mc(MD_CLESS, 1'b1, 1'b0, 16'he020, 1'b1);
		mc(MD_CLESS, 1'b1, 1'b0, 16'he02f, 1'b1);
		mc(MD_CLESS, 1'b1, 1'b0, 16'he030, 1'b0);
		mc(MD_CLESS, 1'b0, 1'b0, 16'he01f, 1'b0);
		$display("Test exchange window done");
	endtask

	task automatic t_key();
		mmuac_cpu_model_inst.set_seg(5'h1e);
		sw(MD_USER, SFR_KEY_A, 8'h3c, 1'b1);
		chk(key_ff, KEY_RST, "key kept");
		mmuac_cpu_model_inst.set_seg(5'h1f);
		sw(MD_USER, SFR_KEY_A, 8'h3c, 1'b0);
		chk(key_ff, 8'h3c, "key by user");
		sw(MD_SYS, SFR_KEY_A, 8'hc3, 1'b0);
		chk({6'h0, r_ack, r_deny}, 8'h03, "reduced key write");
		chk(key_ff, 8'hc3, "key by system");
		sr(MD_SYS, SFR_KEY_A, RD_ZERO, 1'b1);
		chk(key_red, KEY_RST, "reduced key");
		sr(MD_SYS, 8'h30, RD_ZERO, 1'b1);
		sw(MD_SYS, 8'h30, 8'hff, 1'b1);
		$display("Test key register done");
	endtask

	// Enable low must freeze both the base and the register answer
	task automatic t_ce();
		logic [7:0] rd;
		logic de, ak;
		@(posedge clk);
		#1;
		ce = 1'b0;
		mmuac_cpu_model_inst.sfr(MD_SYS, 1'b1, SFR_STB_LO, 8'h77, rd, de,
			ak);
		ce = 1'b1;
		chk(stb_lo_ff, 8'h55, "base frozen");
		chk({7'h0, ak}, 8'h00, "answer frozen");
		$display("Test clock enable done");
	endtask

	task automatic t_rereset();
		@(posedge clk);
		#1;
		rst_n = 1'b0;
		repeat (2) @(posedge clk);
		#1;
		rst_n = 1'b1;
		chk(stb_lo_ff, STB_RST, "base low again");
		chk(stb_hi_ff, STB_RST, "base high again");
		chk(key_ff, KEY_RST, "key again");
		chk({7'h0, segs_en_ff}, 8'h00, "segments again");
		mc(MD_USER, 1'b0, 1'b1, AEEP_LO, 1'b0);
		$display("Test second reset done");
	endtask

	initial begin
		repeat (6) @(posedge clk);
		#1;
		rst_n = 1'b1;
		t_reset();
		t_seg_cfg();
		t_table();
		t_partition();
		t_xwin();
		t_key();
		t_ce();
		t_rereset();
		print_verdict();
	end
endmodule
